// ---- design/sdtm_defines.vh ----
// Register offsets, field positions, reset values and debounce counts of the supply droop monitor.
`ifndef SDTM_DEFINES_VH
`define SDTM_DEFINES_VH
`define SDTM_OFF_IRQ_PEND      8'h07
`define SDTM_OFF_IRQ_MASK      8'h14
`define SDTM_OFF_WARN_A_CFG    8'hb4
`define SDTM_OFF_WARN_B_CFG    8'hb5
`define SDTM_OFF_CRIT_CFG      8'hb6
`define SDTM_OFF_OUT_A_BEH     8'hb7
`define SDTM_OFF_OUT_B_BEH     8'hb8
`define SDTM_OFF_OUT_CRIT_BEH  8'hb9
`define SDTM_OFF_THROTTLE_BEH  8'hba
`define SDTM_OFF_TRIP_ST       8'hbb
`define SDTM_OFF_OUT_ST        8'hbc
`define SDTM_RST_IRQ_PEND      8'h00
`define SDTM_RST_IRQ_MASK      8'h07
`define SDTM_RST_WARN_CFG      8'h04
`define SDTM_RST_CRIT_CFG      8'h06
`define SDTM_RST_BEH           8'h00
`define SDTM_BIT_PEND_WB       0
`define SDTM_BIT_PEND_WA       1
`define SDTM_BIT_PEND_CRIT     2
`define SDTM_BIT_PEND_SUM      3
`define SDTM_BIT_BEH_EN        0
`define SDTM_BIT_BEH_POL       1
`define SDTM_BIT_BEH_HOLD      2
`define SDTM_BIT_BEH_REL       3
`define SDTM_BIT_CFG_EN        3
`define SDTM_BIT_CRIT_SDWN     4
`define SDTM_BIT_THR_WB        0
`define SDTM_BIT_THR_WA        1
`define SDTM_BIT_THR_ST        2
`define SDTM_DEB_10            8'h0a
`define SDTM_DEB_20            8'h14
`define SDTM_DEB_30            8'h1e
`define SDTM_DEB_100           8'h64
`define SDTM_DEB_BASE          8'h02
`endif

// ---- design/sdtm_debounce.v ----
// Debounced trip qualifier for one supply level with edge events.
`timescale 1ns/1ps
module sdtm_debounce (
	input  wire       clk_sys_i,
	input  wire       rst_n_i,
	input  wire       active_i,
	input  wire       raw_below_i,
	input  wire [7:0] deb_cycles_i,
	output reg        below_o,
	output wire       event_o
);
	reg  [7:0] cnt_q;
	reg        evt_q;

	assign event_o = evt_q;

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q   <= 8'h00;
			below_o <= 1'b0;
			evt_q   <= 1'b0;
		end else begin
			evt_q <= 1'b0;
			if (!active_i) begin
				cnt_q   <= 8'h00;
				below_o <= 1'b0;
			end else if (raw_below_i == below_o) begin
				cnt_q <= 8'h00;
			end else if (cnt_q + 8'h01 >= deb_cycles_i) begin
				cnt_q   <= 8'h00;
				below_o <= raw_below_i;
				evt_q   <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
endmodule // sdtm_debounce

// ---- design/sdtm_monitor.v ----
// Supply droop trip monitor with three debounced levels, output pins and register file.
//
// Operation
// - Three levels, each a 3-bit code from 3.3V down to 2.6V.
// - Qualified warning A crossing drives disable A and raises an interrupt.
// - Qualified warning B crossing drives disable B and raises an interrupt.
// - Qualified critical crossing drives disable critical and raises an interrupt.
// - Crossings are evaluated only in the fully-on platform state.
// - Warning debounce codes map to 2..7, 10, 20, 30 and 100 cycles.
// - Critical debounce codes map to 2..7, 10 and 20 cycles.
// - Shutdown control at 0 starts shutdown below critical; 1 disables it.
// - Disable outputs follow trip conditions with enable, polarity and hold.
// - Throttle output combines temperature results and droop warnings.
// - Output enable 0 never asserts; 1 follows the trip condition.
// - Polarity 0 asserts low; polarity 1 asserts high.
// - Hold 1 keeps an output asserted until software releases it.
// - Release bit written 1 frees held output and clears itself.
// - Trip status reads 1 while supply is below each level.
// - Output status reads 1 while each output is asserted.
// - Each qualified entry and exit sets summary and level pending bits.
// - Recovery deasserts the level output unless held; its throttle deasserts regardless of hold.
// - Warning B crossing asserts throttle when its enable is set.
`timescale 1ns/1ps
`include "sdtm_defines.vh"
module sdtm_monitor (
	input  wire       clk_sys_i,
	input  wire       rst_n_i,
	input  wire       below_a_raw_i,
	input  wire       below_b_raw_i,
	input  wire       below_crit_raw_i,
	input  wire       platform_fully_on_state_i,
	input  wire       temp_throttle_req_i,
	input  wire [7:0] reg_addr_i,
	input  wire [7:0] reg_wdata_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	output reg  [7:0] reg_rdata_o,
	output wire [2:0] warn_a_level_o,
	output wire [2:0] warn_b_level_o,
	output wire [2:0] critical_level_o,
	output wire       droop_disable_a_pin_o,
	output wire       droop_disable_b_pin_o,
	output wire       disable_critical_pin_o,
	output wire       processor_throttle_n_o,
	output reg        shutdown_req_o,
	output wire       irq_n_o
);
	// Warning debounce code to cycle count.
	function [7:0] warn_deb;
		input [3:0] code;
		begin
			if (code <= 4'h5)
				warn_deb = `SDTM_DEB_BASE + {4'h0, code};
			else if (code == 4'h6)
				warn_deb = `SDTM_DEB_10;
			else if (code == 4'h7)
				warn_deb = `SDTM_DEB_20;
			else if (code == 4'h8)
				warn_deb = `SDTM_DEB_30;
			else
				warn_deb = `SDTM_DEB_100;
		end
	endfunction

	// Hold-aware asserted state of one disable output.
	function out_next;
		input [7:0] beh;
		input       cond;
		input       cur;
		begin
			if (!beh[`SDTM_BIT_BEH_EN])
				out_next = 1'b0;
			else if (cond)
				out_next = 1'b1;
			else if (beh[`SDTM_BIT_BEH_HOLD] && !beh[`SDTM_BIT_BEH_REL])
				out_next = cur;
			else
				out_next = 1'b0;
		end
	endfunction

	// Write strobe aimed at one register offset.
	function wr_hit;
		input       wr;
		input [7:0] addr;
		input [7:0] off;
		begin
			wr_hit = wr && (addr == off);
		end
	endfunction

	reg [7:0] pend_q;
	reg [7:0] mask_q;
	reg [7:0] cfg_a_q;
	reg [7:0] cfg_b_q;
	reg [7:0] cfg_c_q;
	reg [7:0] beh_a_q;
	reg [7:0] beh_b_q;
	reg [7:0] beh_c_q;
	reg [7:0] beh_t_q;
	reg       out_a_q;
	reg       out_b_q;
	reg       out_c_q;
	reg       thr_a_q;
	reg       thr_b_q;
	reg [2:0] raw_s1_q;
	reg [2:0] raw_s2_q;
	reg [1:0] on_sync_q;
	reg [1:0] temp_sync_q;
	reg       pulse_sum;

	wire       s0_on;
	wire       temp_hot;
	wire       below_a;
	wire       below_b;
	wire       below_c;
	wire       evt_a;
	wire       evt_b;
	wire       evt_c;
	wire       throttle;
	wire [7:0] trip_st;
	wire [7:0] out_st;
	wire       wr_pend;

	assign s0_on    = on_sync_q[1];
	assign temp_hot = temp_sync_q[1];

	// Comparator outputs and state pins are synchronised before use.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			raw_s1_q    <= 3'h0;
			raw_s2_q    <= 3'h0;
			on_sync_q   <= 2'h0;
			temp_sync_q <= 2'h0;
		end else begin
			raw_s1_q    <= {below_crit_raw_i, below_b_raw_i, below_a_raw_i};
			raw_s2_q    <= raw_s1_q;
			on_sync_q   <= {on_sync_q[0], platform_fully_on_state_i};
			temp_sync_q <= {temp_sync_q[0], temp_throttle_req_i};
		end
	end

	assign warn_a_level_o   = cfg_a_q[2:0];
	assign warn_b_level_o   = cfg_b_q[2:0];
	assign critical_level_o = cfg_c_q[2:0];

	sdtm_debounce u_deb_a (
		.clk_sys_i    (clk_sys_i),
		.rst_n_i      (rst_n_i),
		.active_i     (s0_on & cfg_a_q[`SDTM_BIT_CFG_EN]),
		.raw_below_i  (raw_s2_q[0]),
		.deb_cycles_i (warn_deb(cfg_a_q[7:4])),
		.below_o      (below_a),
		.event_o      (evt_a)
	);

	sdtm_debounce u_deb_b (
		.clk_sys_i    (clk_sys_i),
		.rst_n_i      (rst_n_i),
		.active_i     (s0_on & cfg_b_q[`SDTM_BIT_CFG_EN]),
		.raw_below_i  (raw_s2_q[1]),
		.deb_cycles_i (warn_deb(cfg_b_q[7:4])),
		.below_o      (below_b),
		.event_o      (evt_b)
	);

	sdtm_debounce u_deb_c (
		.clk_sys_i    (clk_sys_i),
		.rst_n_i      (rst_n_i),
		.active_i     (s0_on & cfg_c_q[`SDTM_BIT_CFG_EN]),
		.raw_below_i  (raw_s2_q[2]),
		.deb_cycles_i (warn_deb({1'b0, cfg_c_q[7:5]})),
		.below_o      (below_c),
		.event_o      (evt_c)
	);

	assign wr_pend = reg_wr_i && (reg_addr_i == `SDTM_OFF_IRQ_PEND);

	always @* begin
		pulse_sum = evt_a | evt_b | evt_c;
	end

	// Write 1 clears a pending bit; a new event in the same cycle wins.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_q <= `SDTM_RST_IRQ_PEND;
		end else begin
			pend_q <= (pend_q & ~(wr_pend ? reg_wdata_i : 8'h00))
				| {4'h0, pulse_sum, evt_c, evt_a, evt_b};
		end
	end

	// Each configuration register is replaced as a whole by a write to its offset.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_q <= `SDTM_RST_IRQ_MASK;
		end else if (wr_hit(reg_wr_i, reg_addr_i, `SDTM_OFF_IRQ_MASK)) begin
			mask_q <= {5'h00, reg_wdata_i[2:0]};
		end
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_a_q <= `SDTM_RST_WARN_CFG;
		end else if (wr_hit(reg_wr_i, reg_addr_i, `SDTM_OFF_WARN_A_CFG)) begin
			cfg_a_q <= reg_wdata_i;
		end
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_b_q <= `SDTM_RST_WARN_CFG;
		end else if (wr_hit(reg_wr_i, reg_addr_i, `SDTM_OFF_WARN_B_CFG)) begin
			cfg_b_q <= reg_wdata_i;
		end
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_c_q <= `SDTM_RST_CRIT_CFG;
		end else if (wr_hit(reg_wr_i, reg_addr_i, `SDTM_OFF_CRIT_CFG)) begin
			cfg_c_q <= reg_wdata_i;
		end
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			beh_a_q <= `SDTM_RST_BEH;
		end else if (wr_hit(reg_wr_i, reg_addr_i, `SDTM_OFF_OUT_A_BEH)) begin
			beh_a_q <= {4'h0, reg_wdata_i[3:0]};
		end else begin
			beh_a_q[`SDTM_BIT_BEH_REL] <= 1'b0;
		end
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			beh_b_q <= `SDTM_RST_BEH;
		end else if (wr_hit(reg_wr_i, reg_addr_i, `SDTM_OFF_OUT_B_BEH)) begin
			beh_b_q <= {4'h0, reg_wdata_i[3:0]};
		end else begin
			beh_b_q[`SDTM_BIT_BEH_REL] <= 1'b0;
		end
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			beh_c_q <= `SDTM_RST_BEH;
		end else if (wr_hit(reg_wr_i, reg_addr_i, `SDTM_OFF_OUT_CRIT_BEH)) begin
			beh_c_q <= {4'h0, reg_wdata_i[3:0]};
		end else begin
			beh_c_q[`SDTM_BIT_BEH_REL] <= 1'b0;
		end
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			beh_t_q <= `SDTM_RST_BEH;
		end else if (wr_hit(reg_wr_i, reg_addr_i, `SDTM_OFF_THROTTLE_BEH)) begin
			beh_t_q <= {5'h00, reg_wdata_i[2:0]};
		end
	end

	// Disable outputs, throttle assertions from warning zones and the shutdown request.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_a_q <= 1'b0;
		end else begin
			out_a_q <= out_next(beh_a_q, below_a, out_a_q);
		end
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_b_q <= 1'b0;
		end else begin
			out_b_q <= out_next(beh_b_q, below_b, out_b_q);
		end
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_c_q <= 1'b0;
		end else begin
			out_c_q <= out_next(beh_c_q, below_c, out_c_q);
		end
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			thr_a_q <= 1'b0;
		end else begin
			thr_a_q <= beh_t_q[`SDTM_BIT_THR_WA] & below_a;
		end
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			thr_b_q <= 1'b0;
		end else begin
			thr_b_q <= beh_t_q[`SDTM_BIT_THR_WB] & below_b;
		end
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shutdown_req_o <= 1'b0;
		end else begin
			shutdown_req_o <= below_c & ~cfg_c_q[`SDTM_BIT_CRIT_SDWN];
		end
	end

	assign throttle = temp_hot | thr_a_q | thr_b_q;

	// Pin level equals polarity when asserted and its inverse otherwise.
	assign droop_disable_a_pin_o  = ~(out_a_q ^ beh_a_q[`SDTM_BIT_BEH_POL]);
	assign droop_disable_b_pin_o  = ~(out_b_q ^ beh_b_q[`SDTM_BIT_BEH_POL]);
	assign disable_critical_pin_o = ~(out_c_q ^ beh_c_q[`SDTM_BIT_BEH_POL]);
	assign processor_throttle_n_o = ~throttle;

	assign irq_n_o = ~(|(pend_q[2:0] & ~mask_q[2:0]));

	assign trip_st = {5'h00, below_c, below_a, below_b};
	assign out_st  = {4'h0, throttle, out_a_q, out_b_q, out_c_q};

	// Read data is registered; unmapped offsets read zero.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`SDTM_OFF_IRQ_PEND:     reg_rdata_o <= pend_q;
				`SDTM_OFF_IRQ_MASK:     reg_rdata_o <= mask_q;
				`SDTM_OFF_WARN_A_CFG:   reg_rdata_o <= cfg_a_q;
				`SDTM_OFF_WARN_B_CFG:   reg_rdata_o <= cfg_b_q;
				`SDTM_OFF_CRIT_CFG:     reg_rdata_o <= cfg_c_q;
				`SDTM_OFF_OUT_A_BEH:    reg_rdata_o <= beh_a_q;
				`SDTM_OFF_OUT_B_BEH:    reg_rdata_o <= beh_b_q;
				`SDTM_OFF_OUT_CRIT_BEH: reg_rdata_o <= beh_c_q;
				`SDTM_OFF_THROTTLE_BEH: reg_rdata_o <= {beh_t_q[7:3], throttle, beh_t_q[1:0]};
				`SDTM_OFF_TRIP_ST:      reg_rdata_o <= trip_st;
				`SDTM_OFF_OUT_ST:       reg_rdata_o <= out_st;
				default:                reg_rdata_o <= 8'h00;
			endcase
		end
	end
endmodule // sdtm_monitor

// ---- verification/sdtm_host_model.sv ----
// Host processor model that counts interrupt requests from the monitor.
`timescale 1ns/1ps
module sdtm_host_model (
	input  wire    clk_sys_i,
	input  wire    rst_n_i,
	input  wire    irq_n_i,
	output integer irq_cnt_o
);
	logic irq_n_q;
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_n_q   <= 1'b1;
			irq_cnt_o <= 0;
		end else begin
			irq_n_q <= irq_n_i;
			if (irq_n_q && !irq_n_i) irq_cnt_o <= irq_cnt_o + 1;
		end
	end
endmodule // sdtm_host_model

// ---- verification/sdtm_chk_monitor.sv ----
// Port checker for the supply droop trip monitor.
`timescale 1ns/1ps
module sdtm_chk (
	input  wire       clk_sys_i,
	input  wire       rst_n_i,
	input  wire       below_crit_raw_i,
	input  wire       platform_fully_on_state_i,
	input  wire       temp_throttle_req_i,
	input  wire [7:0] reg_addr_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	input  wire [7:0] reg_rdata_o,
	input  wire [2:0] warn_a_level_o,
	input  wire [2:0] critical_level_o,
	input  wire       processor_throttle_n_o,
	input  wire       shutdown_req_o,
	input  wire       irq_n_o,
	input  wire       droop_disable_a_pin_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_temp_held;
		temp_throttle_req_i [*4];
	endsequence
	sequence s_off_s0;
		!platform_fully_on_state_i [*6];
	endsequence
	AST_LEVEL_A: assert property (!(reg_wr_i && reg_addr_i == 8'hb4) |=> $stable(warn_a_level_o))
		else $error("Warning A level code moved without a write.");
	AST_LEVEL_CRIT: assert property (!(reg_wr_i && reg_addr_i == 8'hb6) |=> $stable(critical_level_o))
		else $error("Critical level code moved without a write.");
	AST_RDATA_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("Read data changed without a read.");
	AST_SHUT_S0: assert property (s_off_s0 |-> !shutdown_req_o)
		else $error("Shutdown request outside the fully on state.");
	AST_SHUT_CAUSE: assert property ($rose(shutdown_req_o) |-> $past(below_crit_raw_i, 4))
		else $error("Shutdown request without a critical crossing.");
	AST_THR_TEMP: assert property (s_temp_held |-> !processor_throttle_n_o)
		else $error("Temperature request did not throttle.");
	AST_IRQ_HOLD: assert property (!irq_n_o && !(reg_wr_i && (reg_addr_i == 8'h07 ||
		reg_addr_i == 8'h14)) |=> !irq_n_o)
		else $error("Interrupt line released without a clear or mask.");
	AST_RESET_OUT: assert property ($rose(rst_n_i) |-> irq_n_o && processor_throttle_n_o &&
		!shutdown_req_o && droop_disable_a_pin_o)
		else $error("Outputs not idle after reset.");
endmodule // sdtm_chk
bind sdtm_monitor sdtm_chk u_chk (.clk_sys_i, .rst_n_i, .below_crit_raw_i,
	.platform_fully_on_state_i, .temp_throttle_req_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
	.reg_rdata_o, .warn_a_level_o, .critical_level_o, .processor_throttle_n_o, .shutdown_req_o,
	.irq_n_o, .droop_disable_a_pin_o);

// ---- verification/sdtm_testbench.sv ----
// Self-checking bench for the supply droop trip monitor.
`timescale 1ns/1ps
module testbench;
	logic       clk_sys_i = 1'b0;
	logic       rst_n_i   = 1'b0;
	logic [2:0] raw       = 3'h0;
	logic       s0        = 1'b1;
	logic       temp      = 1'b0;
	logic [7:0] addr      = 8'h00;
	logic [7:0] wdata     = 8'h00;
	logic       wr        = 1'b0;
	logic       rd        = 1'b0;
	logic [7:0] rv;
	wire  [7:0] rdata;
	wire  [2:0] lvl_a;
	wire  [2:0] lvl_b;
	wire  [2:0] lvl_c;
	wire  [2:0] pin;
	wire        thr_n;
	wire        sdwn;
	wire        irq_n;
	integer     irq_cnt;
	integer     n_fail      = 0;
	integer     comparisons = 0;
	integer     n0;
	integer     n1;
	integer     i;
	integer     deb [10]    = '{2, 3, 4, 5, 6, 7, 10, 20, 30, 100};
	logic [3:0] code [10]   = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf};
	logic [7:0] offs [11]   = '{8'h07, 8'h14, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hb8, 8'hb9, 8'hbb,
		8'hbc, 8'h20};
	logic [7:0] vals [11]   = '{8'h00, 8'h07, 8'h04, 8'h04, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};
	sdtm_monitor dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .below_a_raw_i(raw[0]),
		.below_b_raw_i(raw[1]), .below_crit_raw_i(raw[2]), .platform_fully_on_state_i(s0),
		.temp_throttle_req_i(temp), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .warn_a_level_o(lvl_a), .warn_b_level_o(lvl_b),
		.critical_level_o(lvl_c), .droop_disable_a_pin_o(pin[0]),
		.droop_disable_b_pin_o(pin[1]), .disable_critical_pin_o(pin[2]),
		.processor_throttle_n_o(thr_n), .shutdown_req_o(sdwn), .irq_n_o(irq_n));
	sdtm_host_model u_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .irq_n_i(irq_n),
		.irq_cnt_o(irq_cnt));
	initial forever #25 clk_sys_i = ~clk_sys_i;
	task automatic tick();
		@(posedge clk_sys_i);
		#1;
	endtask
	task automatic complete_run();
		if (n_fail == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		tick();
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick();
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		tick();
		addr = a;
		rd = 1'b1;
		tick();
		rd = 1'b0;
		d = rdata;
	endtask
	task automatic wait_pin(input integer k, input logic v, output integer n);
		n = 0;
		while (pin[k] !== v && n < 300) begin
			tick();
			n++;
		end
		if (n >= 300) begin
			n_fail++;
			complete_run();
		end
	endtask
	initial begin
		repeat (6) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		for (i = 0; i < 11; i++) begin
			rd_reg(offs[i], rv);
			check(rv, vals[i]);
		end
		wr_reg(8'hbb, 8'hff);
		rd_reg(8'hbb, rv);
		check(rv, 8'h00);
		check({5'h00, lvl_c}, 8'h06);
		wr_reg(8'h14, 8'h05);
		wr_reg(8'hb7, 8'h03);
		for (i = 0; i < 10; i++) begin
			wr_reg(8'hb4, {code[i], 4'h9});
			raw[0] = 1'b1;
			wait_pin(0, 1'b1, n1);
			if (i == 0) n0 = n1;
			check(8'(n1 - n0), 8'(deb[i] - 2));
			rd_reg(8'h07, rv);
			check(rv, 8'h0a);
			check({7'h00, irq_n}, 8'h00);
			rd_reg(8'hbb, rv);
			check(rv, 8'h02);
			rd_reg(8'hbc, rv);
			check(rv, 8'h04);
			wr_reg(8'h07, 8'h0f);
			raw[0] = 1'b0;
			wait_pin(0, 1'b0, n1);
			rd_reg(8'h07, rv);
			check(rv, 8'h0a);
			wr_reg(8'h07, 8'h0f);
		end
		check({5'h00, lvl_a}, 8'h01);
		check(8'(irq_cnt), 8'h14);
		wr_reg(8'h14, 8'h07);
		raw[0] = 1'b1;
		wait_pin(0, 1'b1, n1);
		repeat (3) tick();
		check({7'h00, irq_n}, 8'h01);
		rd_reg(8'h07, rv);
		check(rv, 8'h0a);
		wr_reg(8'h07, 8'h0f);
		s0 = 1'b0;
		repeat (20) tick();
		check({7'h00, pin[0]}, 8'h00);
		rd_reg(8'h07, rv);
		check(rv, 8'h00);
		raw[0] = 1'b0;
		s0 = 1'b1;
		wr_reg(8'hb9, 8'h05);
		for (i = 0; i < 3; i++) begin
			wr_reg(8'hb6, {(i == 0) ? 3'h0 : 3'h7, (i == 2) ? 5'h1d : 5'h0d});
			raw[2] = 1'b1;
			wait_pin(2, 1'b0, n1);
			if (i == 0) n0 = n1;
			if (i == 1) check(8'(n1 - n0), 8'h12);
			repeat (3) tick();
			check({7'h00, sdwn}, (i == 2) ? 8'h00 : 8'h01);
			if (i == 0) begin
				s0 = 1'b0;
				repeat (8) tick();
				check({7'h00, sdwn}, 8'h00);
				s0 = 1'b1;
				repeat (8) tick();
				check({7'h00, sdwn}, 8'h01);
			end
			raw[2] = 1'b0;
			repeat (40) tick();
			check({7'h00, pin[2]}, 8'h00);
			wr_reg(8'hb9, 8'h0d);
			rd_reg(8'hb9, rv);
			check(rv, 8'h05);
			check({7'h00, pin[2]}, 8'h01);
		end
		wr_reg(8'hb5, 8'h0b);
		wr_reg(8'hba, 8'h01);
		raw[1] = 1'b1;
		repeat (10) tick();
		check({7'h00, pin[1]}, 8'h01);
		check({7'h00, thr_n}, 8'h00);
		rd_reg(8'hbc, rv);
		check(rv, 8'h08);
		raw[1] = 1'b0;
		repeat (10) tick();
		check({7'h00, thr_n}, 8'h01);
		temp = 1'b1;
		repeat (6) tick();
		check({7'h00, thr_n}, 8'h00);
		temp = 1'b0;
		complete_run();
	end
endmodule // testbench
